// [hw/itsc_pkg.sv]
// Package: constants and carriers for the trigger, status and output control block
package itsc_pkg;

    // ----------------------------------------
    // Register map (byte addresses)
    // ----------------------------------------
    localparam logic [11:0] ITSC_CTRL_ADDR = 12'h000;
    localparam logic [11:0] ITSC_FLAGS_ADDR = 12'h004;
    localparam logic [11:0] ITSC_SPECIAL_ADDR = 12'h008;
    localparam logic [11:0] ITSC_STATE_ADDR = 12'h00C;
    localparam logic [11:0] ITSC_INT_STATUS_ADDR = 12'h010;
    localparam logic [11:0] ITSC_INT_ENABLE_ADDR = 12'h014;
    localparam logic [11:0] ITSC_INT_CLEAR_ADDR = 12'h018;
    localparam logic [11:0] ITSC_LAST_ADDR = 12'h01C;

    // ----------------------------------------
    // Field positions
    // ----------------------------------------
    localparam int ITSC_CTRL_TRIG_BIT = 0;
    localparam int ITSC_CTRL_SWRST_BIT = 1;
    localparam int ITSC_STAT_INTEGRITY_BIT = 7;
    localparam int ITSC_STAT_STARTUP_BIT = 6;
    localparam int ITSC_STAT_ENVIRON_BIT = 5;
    localparam int ITSC_STAT_OVERLOAD_BIT = 4;
    localparam int ITSC_STAT_CHERR_BIT = 3;
    localparam int ITSC_INT_DGRAM_BIT = 0;
    localparam int ITSC_INT_FAULT_BIT = 1;
    localparam int ITSC_INT_DROP_BIT = 2;

    // ----------------------------------------
    // Reset values and timing
    // ----------------------------------------
    localparam logic [31:0] ITSC_CTRL_RESET = 32'h0000_0000;
    localparam logic [2:0] ITSC_INT_RESET = 3'h0;
    localparam int ITSC_CLK_HZ = 40_000_000;
    localparam int ITSC_SAMPLE_RATE_HZ = 2000;
    localparam int ITSC_SAMPLE_CYCLES = ITSC_CLK_HZ / ITSC_SAMPLE_RATE_HZ;
    localparam int ITSC_INIT_DGRAMS = 3;
    localparam int ITSC_STARTUP_MS = 100;
    localparam int ITSC_STARTUP_CYCLES = ITSC_STARTUP_MS * (ITSC_CLK_HZ / 1000);
    localparam int ITSC_FRAME_CYCLES = 16000;

    // ----------------------------------------
    // Types
    // ----------------------------------------
    typedef enum logic [1:0] {
        ITSC_ST_INIT = 2'b00,
        ITSC_ST_STARTUP = 2'b01,
        ITSC_ST_NORMAL = 2'b10
    } itsc_mode_t;

    typedef struct packed {
        logic integrity;
        logic startup;
        logic environ;
        logic overload;
        logic ch_error;
        logic [2:0] axis;
    } itsc_status_t;

    typedef struct packed {
        logic valid;
        logic special;
        logic [7:0] kind;
        itsc_status_t status;
    } itsc_dgram_t;

endpackage

// [hw/itsc_top.sv]
// Top: trigger, reset, status byte and datagram release control over APB
//
// The APB slave port and the placing of the registers were left to the implementer.
`timescale 1ns/1ps

module itsc_top
    import itsc_pkg::*;
#(
    parameter int STARTUP_CYCLES = ITSC_STARTUP_CYCLES,
    parameter int FRAME_CYCLES = ITSC_FRAME_CYCLES,
    parameter int SAMPLE_CYCLES = ITSC_SAMPLE_CYCLES
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic hw_reset_low,
    input wire logic transmit_request_pin,
    input wire logic dgram_done,
    output logic validity_strobe,
    output itsc_dgram_t dgram,
    output logic irq
);

    initial begin
        if (SAMPLE_CYCLES < 2 || FRAME_CYCLES < 1 || STARTUP_CYCLES < 1) begin
            $error("itsc_top: counts too small");
        end
    end

    // ----------------------------------------
    // Pin synchronisers
    // ----------------------------------------
    // Three stages; a level counts once stages two and three agree
    // Idle levels after reset match the pull-ups, so no false edge
    logic [2:0] rst_sync;
    logic [2:0] trig_sync;
    logic rst_level;
    logic trig_level;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rst_sync <= 3'h7;
            trig_sync <= 3'h7;
        end else begin
            rst_sync <= {rst_sync[1:0], hw_reset_low};
            trig_sync <= {trig_sync[1:0], transmit_request_pin};
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rst_level <= 1'b1;
            trig_level <= 1'b1;
        end else begin
            if (rst_sync[1] == rst_sync[2]) begin
                rst_level <= rst_sync[2];
            end
            if (trig_sync[1] == trig_sync[2]) begin
                trig_level <= trig_sync[2];
            end
        end
    end

    wire logic trig_agree = (trig_sync[1] == trig_sync[2]);
    wire logic trig_fall = trig_agree && !trig_sync[2] && trig_level;
    wire logic pin_reset = !rst_level;

    // ----------------------------------------
    // APB decode
    // ----------------------------------------
    logic [31:0] ctrl;
    logic [7:0] flags;
    logic [7:0] special_kind;
    logic special_pend;
    logic [2:0] int_status;
    logic [2:0] int_enable;
    itsc_mode_t mode;

    // No wait states: pready is registered from the setup phase
    wire logic acc = psel && penable;
    wire logic wr = acc && pwrite;
    wire logic addr_ok = (paddr <= ITSC_LAST_ADDR) && (paddr[1:0] == 2'h0);
    wire logic wr_ctrl = wr && paddr == ITSC_CTRL_ADDR;
    wire logic wr_flags = wr && paddr == ITSC_FLAGS_ADDR;
    wire logic wr_special = wr && paddr == ITSC_SPECIAL_ADDR;
    wire logic wr_ien = wr && paddr == ITSC_INT_ENABLE_ADDR;
    wire logic wr_iclr = wr && paddr == ITSC_INT_CLEAR_ADDR;
    wire logic trig_mode = ctrl[ITSC_CTRL_TRIG_BIT];
    wire logic soft_reset = wr_ctrl && pwdata[ITSC_CTRL_SWRST_BIT];
    wire logic ctl_reset = pin_reset || soft_reset;

    wire logic [31:0] rd_mux =
        (paddr == ITSC_CTRL_ADDR) ? ctrl :
        (paddr == ITSC_FLAGS_ADDR) ? {24'h0, flags} :
        (paddr == ITSC_SPECIAL_ADDR) ? {23'h0, special_pend, special_kind} :
        (paddr == ITSC_STATE_ADDR) ? {29'h0, rst_level, mode} :
        (paddr == ITSC_INT_STATUS_ADDR) ? {29'h0, int_status} :
        (paddr == ITSC_INT_ENABLE_ADDR) ? {29'h0, int_enable} :
        32'h0;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= 32'h0;
            pready <= 1'b0;
            pslverr <= 1'b0;
        end else begin
            pready <= psel && !penable;
            pslverr <= psel && !penable && !addr_ok;
            prdata <= (psel && !penable && !pwrite) ? rd_mux : 32'h0;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl <= ITSC_CTRL_RESET;
            flags <= 8'h00;
            int_enable <= ITSC_INT_RESET;
        end else begin
            // Soft reset bit acts as a strobe and is never stored
            if (wr_ctrl) begin
                ctrl <= {31'h0, pwdata[ITSC_CTRL_TRIG_BIT]};
            end
            if (wr_flags) begin
                flags <= pwdata[7:0];
            end
            if (wr_ien) begin
                int_enable <= pwdata[2:0];
            end
        end
    end

    // ----------------------------------------
    // Mode and sample timing
    // ----------------------------------------
    // Internal sampling never stops, even in triggered mode
    logic [31:0] samp_cnt;
    logic [31:0] startup_cnt;
    logic [1:0] init_left;
    logic busy;
    logic [31:0] frame_cnt;
    itsc_status_t sample_status;

    wire logic sample_tick = (samp_cnt == 32'(SAMPLE_CYCLES - 1));
    // Length cap ends a frame whose receiver never reports done
    wire logic frame_end = busy && (dgram_done || frame_cnt == 32'(FRAME_CYCLES - 1));

    function automatic itsc_status_t pack_status(input logic [7:0] f, input logic st);
        itsc_status_t s;
        s.integrity = f[ITSC_STAT_INTEGRITY_BIT];
        s.startup = st;
        s.environ = f[ITSC_STAT_ENVIRON_BIT];
        s.overload = f[ITSC_STAT_OVERLOAD_BIT];
        s.ch_error = f[ITSC_STAT_CHERR_BIT];
        s.axis = (f[ITSC_STAT_OVERLOAD_BIT] || f[ITSC_STAT_CHERR_BIT]) ? f[2:0] : 3'h0;
        return s;
    endfunction

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            samp_cnt <= 32'h0;
            sample_status <= '{startup: 1'b1, default: '0};
        end else begin
            samp_cnt <= sample_tick ? 32'h0 : samp_cnt + 32'h1;
            if (ctl_reset) begin
                // Data after a reset stays unsettled until start-up ends
                sample_status.startup <= 1'b1;
            end else if (sample_tick) begin
                sample_status <= pack_status(flags, mode != ITSC_ST_NORMAL);
            end
        end
    end

    // ----------------------------------------
    // Datagram release
    // ----------------------------------------
    // A controller held in reset starts nothing
    wire logic run = !ctl_reset;
    wire logic send_init = run && (mode == ITSC_ST_INIT) && !busy && init_left != 2'h0;
    wire logic send_free = run && (mode != ITSC_ST_INIT) && !trig_mode && sample_tick
        && !busy;
    wire logic send_trig = run && (mode != ITSC_ST_INIT) && trig_mode && trig_fall
        && !busy;
    // Requests that find the link busy are lost, not queued
    wire logic dropped = (mode != ITSC_ST_INIT) && busy && (sample_tick || trig_fall);
    wire logic start = send_init || send_free || send_trig;
    wire logic use_special = send_trig && special_pend;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            mode <= ITSC_ST_INIT;
            init_left <= 2'(ITSC_INIT_DGRAMS);
            startup_cnt <= 32'h0;
        end else if (ctl_reset) begin
            mode <= ITSC_ST_INIT;
            init_left <= 2'(ITSC_INIT_DGRAMS);
            startup_cnt <= 32'h0;
        end else begin
            if (send_init) begin
                init_left <= init_left - 2'h1;
            end
            unique case (mode)
                ITSC_ST_INIT: begin
                    if (init_left == 2'h0 && !busy) begin
                        mode <= ITSC_ST_STARTUP;
                    end
                end
                ITSC_ST_STARTUP: begin
                    startup_cnt <= startup_cnt + 32'h1;
                    if (startup_cnt == 32'(STARTUP_CYCLES - 1)) begin
                        mode <= ITSC_ST_NORMAL;
                    end
                end
                ITSC_ST_NORMAL: begin
                    // Leaves only through a reset
                end
                default: mode <= ITSC_ST_INIT;
            endcase
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            special_pend <= 1'b0;
            special_kind <= 8'h00;
        end else if (wr_special) begin
            special_pend <= 1'b1;
            special_kind <= pwdata[7:0];
        end else if (use_special || ctl_reset) begin
            special_pend <= 1'b0;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            busy <= 1'b0;
            frame_cnt <= 32'h0;
            dgram <= '0;
            validity_strobe <= 1'b1;
        end else begin
            dgram.valid <= start;
            if (start) begin
                busy <= 1'b1;
                frame_cnt <= 32'h0;
                dgram.special <= send_init || use_special;
                dgram.kind <= send_init ? {6'h0, init_left} :
                              (use_special ? special_kind : 8'h00);
                dgram.status <= sample_status;
            end else if (frame_end) begin
                busy <= 1'b0;
            end else if (busy) begin
                frame_cnt <= frame_cnt + 32'h1;
            end
            // Falls with the sample in free-running mode, rises when the frame ends
            if (send_free) begin
                validity_strobe <= 1'b0;
            end else if (frame_end) begin
                validity_strobe <= 1'b1;
            end
        end
    end

    // ----------------------------------------
    // Interrupts
    // ----------------------------------------
    // Fault event is a level: bit 1 sets again while any of flags[7:3] stands
    wire logic [2:0] int_events = {dropped, |flags[7:3], frame_end};

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            int_status <= ITSC_INT_RESET;
            irq <= 1'b0;
        end else begin
            // Set wins over a clear in the same cycle
            int_status <= (int_status & ~(wr_iclr ? pwdata[2:0] : 3'h0)) | int_events;
            irq <= |(int_status & int_enable);
        end
    end

endmodule // itsc_top

// [tb/itsc_props.sv]
// Checker: port assertions for the trigger and status block
`timescale 1ns/1ps
module itsc_props
    import itsc_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic [11:0] paddr,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic validity_strobe,
    input wire itsc_dgram_t dgram
);
// ----
// Properties
// ----
default clocking @(posedge pclk); endclocking
default disable iff (!presetn);
sequence setup_s;
    psel && !penable;
endsequence
sequence bad_s;
    paddr > 12'h01C || paddr[1:0] != 2'h0;
endsequence
a_ready_next: assert property (setup_s |=> pready) else $error("no ready");
a_ready_once: assert property (pready |=> !pready) else $error("ready held");
a_err_bad: assert property (setup_s ##0 bad_s |=> pslverr) else $error("no slverr");
a_err_good: assert property (psel && !penable && paddr <= 12'h01C && paddr[1:0] == 2'h0
    |=> !pslverr) else $error("false slverr");
a_valid_pulse: assert property (dgram.valid |=> !dgram.valid) else $error("long valid");
a_strobe_start: assert property ($fell(validity_strobe) |-> ##[0:1] dgram.valid)
    else $error("strobe without frame");
a_axis_quiet: assert property (dgram.valid && !dgram.status.overload
    && !dgram.status.ch_error |-> dgram.status.axis == 3'h0) else $error("stray axis");
a_status_hold: assert property (!dgram.valid |-> $stable(dgram.status))
    else $error("status moved");
endmodule // itsc_props
bind itsc_top itsc_props chk (.pclk, .presetn, .psel, .penable, .paddr, .pready, .pslverr,
    .validity_strobe, .dgram);

// [tb/itsc_host.sv]
// Host model: serial receiver that ends each datagram
`timescale 1ns/1ps
module itsc_host
    import itsc_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire itsc_dgram_t dgram,
    input wire logic [3:0] lat,
    output logic dgram_done
);
logic [3:0] cnt;
logic busy;
// Receiver ends a frame lat + 2 cycles after its valid pulse; one per request
always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
        cnt <= 4'h0;
        busy <= 1'b0;
        dgram_done <= 1'b0;
    end else begin
        dgram_done <= 1'b0;
        if (dgram.valid) begin
            busy <= 1'b1;
            cnt <= lat;
        end else if (busy && cnt == 4'h0) begin
            busy <= 1'b0;
            dgram_done <= 1'b1;
        end else if (busy) begin
            cnt <= cnt - 4'h1;
        end
    end
end
endmodule // itsc_host

// [tb/imu_trigger_status_control_test.sv]
// Testbench: scenarios for the trigger, status and datagram release block
`timescale 1ns/1ps
module imu_trigger_status_control_test
    import itsc_pkg::*;
;
logic pclk, presetn, psel, penable, pwrite, hw_reset_low, transmit_request_pin;
logic [11:0] paddr;
logic [31:0] pwdata, prdata, q;
logic pready, pslverr, dgram_done, validity_strobe, irq, e;
itsc_dgram_t dgram, got;
int n_mismatch, checks;
// Short counts keep the run small
itsc_top #(.STARTUP_CYCLES(50), .FRAME_CYCLES(20), .SAMPLE_CYCLES(40)) uut (.pclk, .presetn,
    .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .hw_reset_low,
    .transmit_request_pin, .dgram_done, .validity_strobe, .dgram, .irq);
itsc_host host (.pclk, .presetn, .dgram, .lat(4'h3), .dgram_done);
initial begin
    pclk = 1'b0;
    forever #12.5 pclk = ~pclk;
end
task chk(input logic ok, input string m);
    checks++;
    if (ok !== 1'b1) begin
        n_mismatch++;
        $display("unexpected at %0t: %s", $time, m);
    end
endtask
task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
endtask
task dg(input int lim);
    int i;
    for (i = 0; i < lim; i++) begin
        @(posedge pclk);
        if (dgram.valid === 1'b1) break;
    end
    got = dgram;
    chk(i < lim, "no datagram");
endtask
task none(input int n);
    repeat (n) begin
        @(posedge pclk);
        if (dgram.valid !== 1'b0) chk(1'b0, "extra datagram");
    end
endtask
task trig();
    @(posedge pclk);
    transmit_request_pin <= 1'b0;
    dg(10);
    repeat (4) @(posedge pclk);
    transmit_request_pin <= 1'b1;
    // Held high long enough for the pin filter to see it
    repeat (6) @(posedge pclk);
endtask
task init3();
    for (int k = 3; k > 0; k--) begin
        dg(200);
        chk(got.special === 1'b1 && got.kind === 8'(k), "init datagram");
    end
endtask
task t_init();
    init3();
    dg(200);
    chk(got.special === 1'b0 && got.status.startup === 1'b1, "startup");
    chk(validity_strobe === 1'b0, "strobe low");
    repeat (8) @(posedge pclk);
    chk(validity_strobe === 1'b1, "strobe high");
    repeat (3) dg(200);
    chk(got.status.startup === 1'b0, "settled");
endtask
task t_flags();
    logic [7:0] f [3];
    logic [7:0] x [3];
    f = '{8'hB5, 8'h0A, 8'h27};
    // Channel bits show only beside an overload or channel fault
    x = '{8'hB5, 8'h0A, 8'h20};
    for (int k = 0; k < 3; k++) begin
        apb(1'b1, ITSC_FLAGS_ADDR, {24'h0, f[k]});
        // Second frame is the first whose sample follows the write
        repeat (2) dg(200);
        chk(got.status === itsc_status_t'(x[k]), "status");
    end
endtask
task t_trig();
    apb(1'b1, ITSC_FLAGS_ADDR, 32'h80);
    apb(1'b1, ITSC_CTRL_ADDR, 32'h1);
    repeat (45) @(posedge pclk);
    none(60);
    trig();
    chk(got.special === 1'b0 && got.status === 8'h80, "newest data");
    none(60);
    apb(1'b1, ITSC_FLAGS_ADDR, 32'h0);
    apb(1'b1, ITSC_SPECIAL_ADDR, 32'h41);
    apb(1'b1, ITSC_SPECIAL_ADDR, 32'h42);
    apb(1'b0, ITSC_SPECIAL_ADDR, 32'h0);
    chk(q === 32'h0000_0142, "pending special");
    trig();
    chk(got.special === 1'b1 && got.kind === 8'h42, "latest special");
    trig();
    chk(got.special === 1'b0, "data again");
endtask
task t_irq();
    apb(1'b0, ITSC_INT_STATUS_ADDR, 32'h0);
    chk(q[0] === 1'b1 && q[1] === 1'b1 && irq === 1'b0, "masked");
    apb(1'b1, ITSC_INT_ENABLE_ADDR, 32'h1);
    repeat (2) @(posedge pclk);
    chk(irq === 1'b1, "irq raised");
    apb(1'b1, ITSC_INT_CLEAR_ADDR, 32'h1);
    repeat (2) @(posedge pclk);
    chk(irq === 1'b0, "irq cleared");
    apb(1'b0, 12'h020, 32'h0);
    chk(e === 1'b1, "unmapped");
endtask
task t_hwrst();
    @(posedge pclk);
    hw_reset_low <= 1'b0;
    repeat (6) @(posedge pclk);
    hw_reset_low <= 1'b1;
    init3();
    apb(1'b1, ITSC_CTRL_ADDR, 32'h2);
    init3();
endtask
task conclude();
    $display("n_mismatch %0d checks %0d", n_mismatch, checks);
    if (n_mismatch == 0 && checks > 0) begin
        $display("Test passed");
    end else begin
        $display("Test failed");
    end
    $finish;
endtask
initial begin
    repeat (20000) @(posedge pclk);
    n_mismatch++;
    conclude();
end
initial begin
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h0;
    pwdata = 32'h0;
    hw_reset_low = 1'b1;
    transmit_request_pin = 1'b1;
    n_mismatch = 0;
    checks = 0;
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    t_init();
    t_flags();
    t_trig();
    t_irq();
    t_hwrst();
    conclude();
end
endmodule // imu_trigger_status_control_test
